// [design/plcc_pkg.sv]
// Purpose: constants and types for the loop calculation core
// Assumes: 16-bit loop table words, 4-bit word index on the register port
// Notes: register word offsets are shared by the core and the bench
package plcc_pkg;

  // ----------------------------------------------------------------
  // register word offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_SP = 4'h1;
  localparam logic [3:0] OFS_PV = 4'h2;
  localparam logic [3:0] OFS_KP = 4'h3;
  localparam logic [3:0] OFS_KI = 4'h4;
  localparam logic [3:0] OFS_COUT = 4'h5;
  localparam logic [3:0] OFS_KD = 4'h6;
  localparam logic [3:0] OFS_UPPER = 4'h7;
  localparam logic [3:0] OFS_LOWER = 4'h8;
  localparam logic [3:0] OFS_DBAND = 4'h9;
  localparam logic [3:0] OFS_DLIM = 4'ha;
  localparam logic [3:0] OFS_HTHR = 4'hb;
  localparam logic [3:0] OFS_DTHR = 4'hc;
  localparam logic [3:0] OFS_STAT = 4'hd;
  localparam logic [3:0] OFS_CHAN = 4'he;

  // ----------------------------------------------------------------
  // loop mode setting word bits
  // ----------------------------------------------------------------
  localparam int MB_AUTO = 0;
  localparam int MB_SQRT = 1;
  localparam int MB_ESQ = 2;
  localparam int MB_DBAND = 3;
  localparam int MB_DLIM = 4;
  localparam int MB_IMIN = 5;
  localparam int MB_XFER = 6;
  localparam int MB_FMT = 7;
  localparam int MB_BIP = 8;
  localparam int MB_W15 = 9;
  localparam int MB_FRZ = 10;
  localparam int MB_HALM = 12;
  localparam int MB_DALM = 13;
  localparam int MB_INDEP = 15;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [15:0] FULL12 = 16'h0fff;
  localparam logic [15:0] FULL15 = 16'h7fff;
  localparam logic [15:0] RST_UPPER = 16'h0fff;
  localparam logic [15:0] BCD_INF = 16'h9999;
  localparam logic [15:0] GAIN_SCALE = 16'h0064;
  localparam logic [15:0] MIN_SECS = 16'h003c;
  localparam logic [4:0] DLIM_MAX = 5'h14;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ERR = 3'b001,
    ST_SHAPE = 3'b010,
    ST_TERMS = 3'b011,
    ST_SUM = 3'b100
  } plcc_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } plcc_bus_s;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] sp;
    logic [15:0] pv;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] kd;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] dband;
    logic [15:0] dlim;
    logic [15:0] hthr;
    logic [15:0] dthr;
    logic [15:0] chan;
    logic [15:0] cout;
  } plcc_regs_s;

  typedef struct packed {
    plcc_state_e st;
    plcc_regs_s r;
    logic [15:0] rdata;
    logic run_calc;
    logic [15:0] pv_eff;
    logic [15:0] pv_prev;
    logic signed [16:0] eraw;
    logic signed [16:0] err;
    logic signed [31:0] bias;
    logic signed [31:0] ptrm;
    logic signed [31:0] itrm;
    logic signed [31:0] dtrm;
    logic [1:0] alarm;
    logic [15:0] ao_data;
    logic [3:0] ao_chan;
    logic ao_strobe;
    logic wrote;
  } plcc_state_s;

endpackage : plcc_pkg

// [design/plcc_core.sv]
// Purpose: one process loop calculation core with register port
// Assumes: sample_tick and cpu_run come from logic on clk_sys
// Notes: one calculation takes five cycles after the tick
`timescale 1ns/1ps

// Behaviour
// R01: clamp output between lower and upper limit
// R02: zero upper limit keeps output at zero
// R03: store new output in word five
// R04: auto-transfer forwards output to chosen channel
// R05: no transfer means output never reaches channel
// R06: per-loop format encodes unipolar or bipolar
// R07: output is P plus I plus D
// R08: gains are four BCD digits, xx.xx
// R09: zero proportional gain drops P term
// R10: integral gain 0000 or 9999 drops I
// R11: integral time unit seconds or minutes
// R12: zero derivative gain drops D term
// R13: optional derivative limit 0 to 20
// R14: error is setpoint minus (rooted) PV
// R15: error squaring keeps the sign
// R16: deadband zeroes small errors
// R17: freeze bias while output out of range
// R18: freeze uses full data range, not limits
// R19: each alarm has own enable and threshold
// R20: manual mode skips calculation, word untouched
// R21: auto mode writes output each sample; the core writes only while cpu_run or mode bit MB_INDEP is set
// R22: one calculation per tick, bias held
// R23: host changes gains only in manual; the core accepts gain writes in any mode
module plcc_core
  import plcc_pkg::*;
#(
  parameter int SAMPLE_CS = 100
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sample_tick,
  input wire logic cpu_run,
  input wire plcc_bus_s bus,
  output logic [15:0] rd_data,
  output logic [15:0] ao_data,
  output logic [3:0] ao_chan,
  output logic ao_strobe,
  output logic [1:0] alarm
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] bcd2bin(input logic [15:0] b);
    bcd2bin = 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]); // R08
  endfunction : bcd2bin

  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [15:0] q;
    logic [15:0] t;
    q = 16'h0000;
    for (int i = 15; i >= 0; i--)
    begin
      t = q | (16'h0001 << i);
      if (32'(t) * 32'(t) <= v)
        q = t;
    end
    isqrt = q;
  endfunction : isqrt

  function automatic logic signed [31:0] abs32(input logic signed [31:0] v);
    abs32 = (v < 0) ? -v : v;
  endfunction : abs32

  function automatic logic signed [31:0] u32(input logic [15:0] v);
    u32 = $signed({16'h0000, v});
  endfunction : u32

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  plcc_state_s state_reg;
  plcc_state_s state_next;

  logic [15:0] fmax;
  logic signed [31:0] e32;
  logic signed [31:0] kp32;
  logic signed [31:0] ki32;
  logic signed [31:0] kd32;
  logic signed [31:0] lim;
  logic signed [31:0] raw;
  logic signed [31:0] outv;
  logic [33:0] sq;
  logic [15:0] sqv;
  logic freeze;
  logic auto_eff;

  assign auto_eff = state_reg.r.mode[MB_AUTO] && (cpu_run || state_reg.r.mode[MB_INDEP]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.wrote = 1'b0;
    state_next.ao_strobe = 1'b0;
    state_next.rdata = 16'h0000;
    fmax = (state_reg.r.mode[MB_FMT] && state_reg.r.mode[MB_W15]) ? FULL15 : FULL12; // R06 R18
    e32 = 32'(state_reg.err);
    kp32 = u32(16'(bcd2bin(state_reg.r.kp)));
    ki32 = u32(16'(bcd2bin(state_reg.r.ki)));
    kd32 = u32(16'(bcd2bin(state_reg.r.kd)));
    lim = 32'sd0;
    raw = 32'sd0;
    outv = 32'sd0;
    sq = 34'h0;
    sqv = 16'h0000;
    freeze = 1'b0;
    if (state_reg.r.mode[MB_IMIN])
      ki32 = ki32 * u32(MIN_SECS); // R11
    if (bus.rd)
    begin
      case (bus.addr)
        OFS_MODE: state_next.rdata = state_reg.r.mode;
        OFS_SP: state_next.rdata = state_reg.r.sp;
        OFS_PV: state_next.rdata = state_reg.r.pv;
        OFS_KP: state_next.rdata = state_reg.r.kp;
        OFS_KI: state_next.rdata = state_reg.r.ki;
        OFS_COUT: state_next.rdata = state_reg.r.cout;
        OFS_KD: state_next.rdata = state_reg.r.kd;
        OFS_UPPER: state_next.rdata = state_reg.r.upper;
        OFS_LOWER: state_next.rdata = state_reg.r.lower;
        OFS_DBAND: state_next.rdata = state_reg.r.dband;
        OFS_DLIM: state_next.rdata = state_reg.r.dlim;
        OFS_HTHR: state_next.rdata = state_reg.r.hthr;
        OFS_DTHR: state_next.rdata = state_reg.r.dthr;
        OFS_STAT: state_next.rdata = {5'h00, state_reg.st, 6'h00, state_reg.alarm};
        OFS_CHAN: state_next.rdata = {12'h000, state_reg.r.chan[3:0]};
        default: state_next.rdata = 16'h0000;
      endcase
    end
    if (bus.wr)
    begin
      case (bus.addr)
        OFS_MODE: state_next.r.mode = bus.wdata;
        OFS_SP: state_next.r.sp = bus.wdata;
        OFS_PV: state_next.r.pv = bus.wdata;
        OFS_KP: state_next.r.kp = bus.wdata;
        OFS_KI: state_next.r.ki = bus.wdata;
        OFS_COUT: state_next.r.cout = bus.wdata; // R20
        OFS_KD: state_next.r.kd = bus.wdata;
        OFS_UPPER: state_next.r.upper = bus.wdata;
        OFS_LOWER: state_next.r.lower = bus.wdata;
        OFS_DBAND: state_next.r.dband = bus.wdata;
        OFS_DLIM: state_next.r.dlim = {11'h000, (bus.wdata[4:0] > DLIM_MAX) ? DLIM_MAX : bus.wdata[4:0]}; // R13
        OFS_HTHR: state_next.r.hthr = bus.wdata;
        OFS_DTHR: state_next.r.dthr = bus.wdata;
        OFS_CHAN: state_next.r.chan = {12'h000, bus.wdata[3:0]};
        default: state_next.r.chan = state_reg.r.chan;
      endcase
    end
    case (state_reg.st)
      ST_IDLE:
      begin
        if (sample_tick)
        begin
          state_next.run_calc = auto_eff; // R22
          state_next.st = ST_ERR;
        end
      end
      ST_ERR:
      begin
        state_next.pv_eff = state_reg.r.mode[MB_SQRT] ?
          isqrt(32'(state_reg.r.pv) * 32'(fmax)) : state_reg.r.pv; // R14
        state_next.st = ST_SHAPE;
      end
      ST_SHAPE:
      begin
        state_next.eraw = $signed({1'b0, state_reg.r.sp}) - $signed({1'b0, state_reg.pv_eff}); // R14
        state_next.err = state_next.eraw;
        if (state_reg.r.mode[MB_ESQ])
        begin
          sq = 34'(abs32(32'(state_next.eraw))) * 34'(abs32(32'(state_next.eraw)));
          sqv = state_reg.r.mode[MB_FMT] && state_reg.r.mode[MB_W15] ? sq[30:15] : sq[27:12];
          state_next.err = state_next.eraw < 0 ? -$signed({1'b0, sqv}) : $signed({1'b0, sqv}); // R15
        end
        if (state_reg.r.mode[MB_DBAND] && abs32(32'(state_next.eraw)) <= u32(state_reg.r.dband))
          state_next.err = 17'sd0; // R16
        state_next.alarm[0] = state_reg.r.mode[MB_HALM] && state_reg.pv_eff > state_reg.r.hthr; // R19
        state_next.alarm[1] = state_reg.r.mode[MB_DALM] &&
          abs32(32'(state_next.eraw)) > u32(state_reg.r.dthr); // R19
        if (state_reg.run_calc)
          state_next.st = ST_TERMS;
        else
        begin
          state_next.pv_prev = state_reg.pv_eff;
          state_next.st = ST_IDLE; // R20
        end
      end
      ST_TERMS:
      begin
        state_next.ptrm = (kp32 * e32) / u32(GAIN_SCALE); // R09
        if (state_reg.r.ki == 16'h0000 || state_reg.r.ki == BCD_INF)
          state_next.itrm = 32'sd0; // R10
        else
          state_next.itrm = (e32 * SAMPLE_CS) / ki32; // R10 R11
        state_next.dtrm = (kd32 * (u32(state_reg.pv_prev) - u32(state_reg.pv_eff))) / SAMPLE_CS; // R12
        if (state_reg.r.mode[MB_DLIM])
        begin
          lim = u32(state_reg.r.dlim) * abs32(e32); // R13
          if (state_next.dtrm > lim)
            state_next.dtrm = lim;
          else if (state_next.dtrm < -lim)
            state_next.dtrm = -lim;
        end
        state_next.st = ST_SUM;
      end
      ST_SUM:
      begin
        raw = state_reg.ptrm + state_reg.bias + state_reg.itrm + state_reg.dtrm; // R07
        freeze = state_reg.r.mode[MB_FRZ] && (raw < 0 || raw > u32(fmax)); // R17 R18
        if (freeze)
          raw = raw - state_reg.itrm; // R17
        else
          state_next.bias = state_reg.bias + state_reg.itrm; // R22
        outv = raw < u32(state_reg.r.lower) ? u32(state_reg.r.lower) : raw; // R01
        outv = outv > u32(state_reg.r.upper) ? u32(state_reg.r.upper) : outv; // R01 R02
        state_next.r.cout = outv[15:0]; // R03 R21
        state_next.wrote = 1'b1;
        state_next.pv_prev = state_reg.pv_eff;
        if (state_reg.r.mode[MB_XFER])
        begin
          state_next.ao_strobe = 1'b1; // R04 R05
          state_next.ao_chan = state_reg.r.chan[3:0]; // R04
          if (state_reg.r.mode[MB_FMT] && state_reg.r.mode[MB_BIP])
            state_next.ao_data = outv[15:0] - ((fmax >> 1) + 16'h0001); // R06
          else
            state_next.ao_data = outv[15:0]; // R06
        end
        state_next.st = ST_IDLE;
      end
      default: state_next.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.r.upper <= RST_UPPER;
    end
    else if (clk_en)
      state_reg <= state_next;
  end

  assign rd_data = state_reg.rdata;
  assign ao_data = state_reg.ao_data;
  assign ao_chan = state_reg.ao_chan;
  assign ao_strobe = state_reg.ao_strobe;
  assign alarm = state_reg.alarm;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_start;
    sample_tick && clk_en && state_reg.st == ST_IDLE && auto_eff;
  endsequence

  sequence s_run;
    clk_en [*4];
  endsequence

  a_tick_write: assert property (s_start ##1 s_run |=> state_reg.wrote) // R21 R22
    else $error("auto tick did not write output in five cycles");

  a_out_upper: assert property (state_reg.wrote |-> state_reg.r.cout <= state_reg.r.upper) // R01
    else $error("output above upper limit");

  a_out_lower: assert property (state_reg.wrote && state_reg.r.lower <= state_reg.r.upper
    |-> state_reg.r.cout >= state_reg.r.lower) // R01
    else $error("output below lower limit");

  a_zero_upper: assert property (state_reg.wrote && state_reg.r.upper == 16'h0000
    |-> state_reg.r.cout == 16'h0000) // R02
    else $error("output nonzero with zero upper limit");

  a_manual_skip: assert property (state_reg.st == ST_SHAPE && !state_reg.run_calc && clk_en
    |=> state_reg.st == ST_IDLE) // R20
    else $error("manual mode entered calculation");

  a_cout_hold: assert property ((state_reg.st != ST_SUM || !clk_en) && !(bus.wr && bus.addr == OFS_COUT)
    |=> state_reg.r.cout == $past(state_reg.r.cout)) // R03 R20
    else $error("output word changed outside a calculation");

  a_xfer_gate: assert property (ao_strobe |-> state_reg.r.mode[MB_XFER] && state_reg.wrote
    && ao_chan == state_reg.r.chan[3:0]) // R04 R05
    else $error("transfer without enable");

  a_p_off: assert property (state_reg.st == ST_SUM && state_reg.r.kp == 16'h0000
    |-> state_reg.ptrm == 32'sd0) // R09
    else $error("proportional term with zero gain");

  a_i_off: assert property (state_reg.st == ST_SUM && (state_reg.r.ki == 16'h0000 || state_reg.r.ki == BCD_INF)
    |-> state_reg.itrm == 32'sd0) // R10
    else $error("integral term with infinite reset");

  a_d_off: assert property (state_reg.st == ST_SUM && state_reg.r.kd == 16'h0000
    |-> state_reg.dtrm == 32'sd0) // R12
    else $error("derivative term with zero gain");

  a_dband_zero: assert property (state_reg.st == ST_TERMS && state_reg.r.mode[MB_DBAND]
    && abs32(32'(state_reg.eraw)) <= u32(state_reg.r.dband) |-> state_reg.err == 17'sd0) // R16
    else $error("error inside deadband not zeroed");

  a_bias_freeze: assert property (state_reg.st == ST_SUM && freeze && clk_en
    |=> state_reg.bias == $past(state_reg.bias)) // R17 R18
    else $error("bias moved while frozen");

endmodule : plcc_core

// [tb/plcc_ao_model.sv]
// Purpose: analog output module model beside the loop core
// Assumes: one value is taken per ao_strobe pulse
// Notes: counts transfers so the bench sees each one
`timescale 1ns/1ps
module plcc_ao_model
(
  input wire logic clk_sys,
  input wire logic ao_strobe,
  input wire logic [15:0] ao_data,
  input wire logic [3:0] ao_chan,
  output logic [15:0] last_data,
  output logic [3:0] last_chan,
  output int xfer_count
);
  // ----------------------------------------------------------------
  // capture each forwarded value
  // ----------------------------------------------------------------
  initial
  begin
    last_data = 16'h0000;
    last_chan = 4'h0;
    xfer_count = 0;
  end
  always @(posedge clk_sys)
  begin
    if (ao_strobe === 1'b1)
    begin
      last_data = ao_data;
      last_chan = ao_chan;
      xfer_count = xfer_count + 1;
    end
  end
endmodule : plcc_ao_model

// [tb/plcc_core_tb.sv]
// Purpose: self-checking bench for the loop calculation core
// Assumes: gains written only while the loop is manual
// Notes: integral and derivative checks start from a fresh reset
`timescale 1ns/1ps
module plcc_core_tb;
  import plcc_pkg::*;
  logic clk_sys, rst_n, clk_en, sample_tick, cpu_run;
  plcc_bus_s bus;
  logic [15:0] rd_data, ao_data, last_data, d, kp, ki;
  logic [3:0] ao_chan, last_chan;
  logic ao_strobe;
  logic [1:0] alarm;
  int xfer_count, num_errors, samples_checked, sp, pv, lo, up, seed;
  localparam logic [15:0] A = 16'h0041;
  localparam logic [15:0] NEG[3] = '{16'd2000, 16'd2000, 16'd1000};

  plcc_core #(.SAMPLE_CS(100)) plcc_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .sample_tick(sample_tick), .cpu_run(cpu_run), .bus(bus), .rd_data(rd_data), .ao_data(ao_data),
    .ao_chan(ao_chan), .ao_strobe(ao_strobe), .alarm(alarm));
  plcc_ao_model plcc_ao_model_i (.clk_sys(clk_sys), .ao_strobe(ao_strobe), .ao_data(ao_data),
    .ao_chan(ao_chan), .last_data(last_data), .last_chan(last_chan), .xfer_count(xfer_count));

  // ----------------------------------------------------------------
  // clock, watchdog, verdict
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    #(40 * 30000);
    num_errors = num_errors + 1;
    complete_run();
  end
  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // bus, loop and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 v = rd_data;
    @(posedge clk_sys);
  endtask : rd
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset
  task automatic setup(input logic [15:0] p, input logic [15:0] i, input logic [15:0] dv, input int u, input int l);
    wr(OFS_MODE, 16'h0000);
    wr(OFS_KP, p);
    wr(OFS_KI, i);
    wr(OFS_KD, dv);
    wr(OFS_UPPER, 16'(u));
    wr(OFS_LOWER, 16'(l));
  endtask : setup
  task automatic lc(input logic [15:0] m, input int s, input int p, input int e, input int ea, input logic fwd);
    int n0;
    logic [15:0] v;
    n0 = xfer_count;
    wr(OFS_SP, 16'(s));
    wr(OFS_PV, 16'(p));
    wr(OFS_MODE, m);
    sample_tick <= 1'b1;
    @(posedge clk_sys);
    sample_tick <= 1'b0;
    repeat (7) @(posedge clk_sys);
    rd(OFS_COUT, v);
    chk(v, 16'(e));
    chk(last_data, 16'(ea));
    chk(16'(xfer_count - n0), {15'h0000, fwd});
  endtask : lc
  function automatic int exp_out(input logic [15:0] g, input int e, input int l, input int u);
    int p;
    p = int'(g[15:12]) * 1000 + int'(g[11:8]) * 100 + int'(g[7:4]) * 10 + int'(g[3:0]);
    p = p * e / 100;
    if (p < l)
      p = l;
    if (p > u)
      p = u;
    return p;
  endfunction : exp_out

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    sample_tick = 1'b0;
    cpu_run = 1'b1;
    bus = '0;
    seed = $urandom(32'h2afc3b93);
    @(posedge clk_sys);
    do_reset();
    rd(OFS_UPPER, d);
    chk(d, RST_UPPER);
    rd(OFS_COUT, d);
    chk(d, 16'h0000);
    rd(4'hf, d);
    chk(d, 16'h0000);
    wr(OFS_DLIM, 16'h00ff);
    rd(OFS_DLIM, d);
    chk(d, 16'h0014);
    wr(OFS_CHAN, 16'hfff3);
    setup(16'h0100, 16'h0000, 16'h0100, 4095, 0);
    wr(OFS_DLIM, 16'h0000);
    wr(OFS_HTHR, 16'd700);
    lc(A, 2000, 1000, 0, 0, 1);
    lc(A, 2000, 1000, 1000, 1000, 1);
    chk({12'h000, last_chan}, 16'h0003);
    lc(A, 2000, 900, 1200, 1200, 1);
    lc(A | 16'h1010, 2000, 800, 1200, 1200, 1);
    chk({14'h0000, alarm}, 16'h0001);
    setup(16'h0100, 16'h9999, 16'h0000, 4095, 0);
    lc(A, 1000, 400, 600, 600, 1);
    lc(16'h0001, 1000, 300, 700, 600, 0);
    lc(16'h0040, 2000, 0, 700, 600, 0);
    cpu_run <= 1'b0;
    lc(A, 2000, 0, 700, 600, 0);
    lc(A | 16'h8000, 1500, 0, 1500, 1500, 1);
    lc(16'h8001, 1400, 0, 1400, 1500, 0);
    cpu_run <= 1'b1;
    wr(OFS_DBAND, 16'd50);
    lc(A | 16'h0008, 1030, 1000, 0, 0, 1);
    lc(A | 16'h0008, 1060, 1000, 60, 60, 1);
    lc(A | 16'h0004, 2000, 0, 976, 976, 1);
    lc(A | 16'h0180, 1000, 0, 1000, 16'hfbe8, 1);
    wr(OFS_DTHR, 16'd900);
    lc(A | 16'h2002, 3000, 1024, 953, 953, 1);
    chk({14'h0000, alarm}, 16'h0002);
    setup(16'h0100, 16'h0000, 16'h0000, 500, 200);
    lc(A, 1100, 1000, 200, 200, 1);
    lc(A, 3100, 0, 500, 500, 1);
    setup(16'h0100, 16'h0000, 16'h0000, 0, 0);
    lc(A, 3000, 0, 0, 0, 1);
    setup(16'h0000, 16'h0000, 16'h0000, 4095, 0);
    lc(A, 3000, 0, 0, 0, 1);
    do_reset();
    setup(16'h0000, 16'h0100, 16'h0000, 4095, 0);
    lc(A, 1100, 1000, 100, 100, 1);
    lc(A, 1100, 1000, 200, 200, 1);
    do_reset();
    setup(16'h0000, 16'h0100, 16'h0000, 4095, 0);
    lc(A | 16'h0020, 600, 0, 10, 10, 1);
    do_reset();
    setup(16'h0000, 16'h0100, 16'h0000, 2000, 0);
    for (int k = 1; k <= 6; k++)
      lc(A | 16'h0400, 1000, 0, (k < 2) ? 1000 : 2000, (k < 2) ? 1000 : 2000, 1);
    for (int k = 0; k < 3; k++)
      lc(A | 16'h0400, 0, 1000, NEG[k], NEG[k], 1);
    do_reset();
    for (int n = 0; n < 16; n++)
    begin
      kp = {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
      ki = ($urandom % 2) ? 16'h9999 : 16'h0000;
      sp = $urandom % 4096;
      pv = $urandom % 4096;
      lo = $urandom % 2048;
      up = $urandom % 4096;
      setup(kp, ki, 16'h0000, up, lo);
      lc(A, sp, pv, exp_out(kp, sp - pv, lo, up), exp_out(kp, sp - pv, lo, up), 1);
    end
    complete_run();
  end
endmodule : plcc_core_tb
